// *** design/mtsop_pkg.sv ***
// constants and carrier types of the matrix tile store / outer product unit
package mtsop_pkg;

    // fixed streaming vector length of this build: 128 bits
    localparam int          SVL_BITS    = 128;
    localparam int          ZA_ROWS     = 16;
    localparam int          NUM_PRED    = 8;
    localparam int          PRED_BITS   = 16;

    // element counts per operation
    localparam logic [4:0]  SLICE_CNT   = 5'h4;
    localparam logic [4:0]  VEC_CNT     = 5'h10;
    localparam logic [4:0]  OUT8_LAST   = 5'hf;
    localparam logic [4:0]  OUT16_LAST  = 5'h3;

    // register byte offsets
    localparam logic [7:0]  OFS_CTRL    = 8'h00;
    localparam logic [7:0]  OFS_CMD     = 8'h04;
    localparam logic [7:0]  OFS_STATUS  = 8'h08;
    localparam logic [7:0]  OFS_ID      = 8'h0c;
    localparam logic [7:0]  OFS_SLICEW  = 8'h10;
    localparam logic [7:0]  OFS_BASE    = 8'h20;
    localparam logic [7:0]  OFS_OFFSET  = 8'h24;
    localparam logic [7:0]  OFS_ZAIDX   = 8'h28;
    localparam logic [7:0]  OFS_ZADATA  = 8'h2c;
    localparam logic [7:0]  OFS_PRED    = 8'h40;
    localparam logic [7:0]  OFS_ZN      = 8'h60;
    localparam logic [7:0]  OFS_ZM      = 8'h70;

    // control register bits
    localparam int          CTRL_MAT_EN = 0;
    localparam int          CTRL_ARR_EN = 1;
    localparam int          CTRL_STREAM = 2;
    localparam int          CTRL_ALIGN  = 3;
    localparam logic [3:0]  CTRL_RESET  = 4'h0;

    // status register bits
    localparam int          STAT_BUSY   = 0;
    localparam int          STAT_ALIGN  = 1;
    localparam int          STAT_UNDEF  = 2;
    localparam int          STAT_DISAB  = 3;
    localparam int          STAT_DONE   = 4;

    // identification register bit
    localparam int          ID_WIDE_BIT = 0;

    // command opcodes
    localparam logic [1:0]  OP_SLICE    = 2'h0;
    localparam logic [1:0]  OP_VEC      = 2'h1;
    localparam logic [1:0]  OP_OUT8     = 2'h2;
    localparam logic [1:0]  OP_OUT16    = 2'h3;
    localparam int          CMD_WIDTH   = 17;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SLICE,
        ST_VEC,
        ST_OUTER
    } mtsop_state_e;

    // command word, op in bits 1:0 up to second predicate in 16:14
    typedef struct packed {
        logic [2:0] secondPred;
        logic [2:0] firstPred;
        logic [3:0] imm;
        logic [1:0] sliceReg;
        logic [2:0] tile;
        logic [1:0] op;
    } mtsop_cmd_s;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic        byteOnly;
    } mtsop_memreq_s;

endpackage : mtsop_pkg

// *** design/mtsop_unit.sv ***
// matrix tile store and mixed-sign outer product unit with AHB-Lite slave
//
// Our own choices: register access over AHB-Lite and the register addresses.
`timescale 1ns/10ps
module mtsop_unit
    import mtsop_pkg::*;
#(
    parameter logic WIDE_PRESENT = 1'b1
) (
    input  wire logic          clk_sys,
    input  wire logic          rstn,
    input  wire logic          hsel,
    input  wire logic [31:0]   haddr,
    input  wire logic [1:0]    htrans,
    input  wire logic          hwrite,
    input  wire logic [2:0]    hsize,
    input  wire logic [31:0]   hwdata,
    input  wire logic          hready,
    output logic               hreadyout,
    output logic               hresp,
    output logic [31:0]        hrdata,
    output logic               memValid,
    output mtsop_memreq_s      memReq,
    input  wire logic          memReady,
    output logic               busy
);

    logic           rstMetaN_q;
    logic           rstSyncN_q;
    logic           dpWrite_q;
    logic           rdPend_q;
    logic           dpMapped_q;
    logic [7:0]     dpAddr_q;
    logic [31:0]    hrdata_q;
    logic [3:0]     ctrl_q;
    mtsop_cmd_s     cmd_q;
    logic [4:0]     stat_q;
    logic [31:0]    sliceW_q [4];
    logic [31:0]    base_q;
    logic [31:0]    offset_q;
    logic [5:0]     zaIdx_q;
    logic [15:0]    pred_q [NUM_PRED];
    logic [127:0]   zn_q;
    logic [127:0]   zm_q;
    logic [127:0]   za_q [ZA_ROWS];
    mtsop_state_e   state_q;
    logic [4:0]     cnt_q;
    logic           reqValid_q;
    mtsop_memreq_s  req_q;

    // reset released through two flops; all other logic uses the copy
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rstMetaN_q <= 1'b0;
            rstSyncN_q <= 1'b0;
        end else begin
            rstMetaN_q <= 1'b1;
            rstSyncN_q <= rstMetaN_q;
        end
    end

    // bus address phase and register decode
    wire         addrPhase = hsel & htrans[1] & hready;
    wire         mapped    = (haddr[31:8] == 24'h0) & (haddr[1:0] == 2'h0);
    wire         idle      = (state_q == ST_IDLE);
    wire         wrEn      = dpWrite_q & dpMapped_q;
    // data registers are frozen while an operation runs
    wire         wrOk      = wrEn & idle;
    wire         wrCtrl    = wrEn & (dpAddr_q == OFS_CTRL);
    wire         wrCmd     = wrOk & (dpAddr_q == OFS_CMD);
    wire         wrBase    = wrOk & (dpAddr_q == OFS_BASE);
    wire         wrOffset  = wrOk & (dpAddr_q == OFS_OFFSET);
    wire         wrZaIdx   = wrOk & (dpAddr_q == OFS_ZAIDX);
    wire         wrZaData  = wrOk & (dpAddr_q == OFS_ZADATA);
    wire         wrSliceW  = wrOk & (dpAddr_q[7:4] == OFS_SLICEW[7:4]);
    wire         wrPred    = wrOk & (dpAddr_q[7:5] == OFS_PRED[7:5]);
    wire         wrZn      = wrOk & (dpAddr_q[7:4] == OFS_ZN[7:4]);
    wire         wrZm      = wrOk & (dpAddr_q[7:4] == OFS_ZM[7:4]);
    wire         rdZaData  = rdPend_q & dpMapped_q
                           & (dpAddr_q == OFS_ZADATA);
    wire [3:0]   zaRowBus  = zaIdx_q[5:2];
    wire [6:0]   zaLaneBus = {zaIdx_q[1:0], 5'h0};

    wire [31:0]  rdMux =
        !dpMapped_q                        ? 32'h0 :
        (dpAddr_q == OFS_CTRL)             ? {28'h0, ctrl_q} :
        (dpAddr_q == OFS_CMD)              ? {15'h0, cmd_q} :
        (dpAddr_q == OFS_STATUS)           ? {27'h0, stat_q} :
        (dpAddr_q == OFS_ID)               ? {31'h0, WIDE_PRESENT} :
        (dpAddr_q[7:4] == OFS_SLICEW[7:4]) ? sliceW_q[dpAddr_q[3:2]] :
        (dpAddr_q == OFS_BASE)             ? base_q :
        (dpAddr_q == OFS_OFFSET)           ? offset_q :
        (dpAddr_q == OFS_ZAIDX)            ? {26'h0, zaIdx_q} :
        (dpAddr_q == OFS_ZADATA)           ? za_q[zaRowBus][zaLaneBus +: 32] :
        (dpAddr_q[7:5] == OFS_PRED[7:5])   ? {16'h0, pred_q[dpAddr_q[4:2]]} :
        (dpAddr_q[7:4] == OFS_ZN[7:4])     ? zn_q[{dpAddr_q[3:2], 5'h0} +: 32] :
        (dpAddr_q[7:4] == OFS_ZM[7:4])     ? zm_q[{dpAddr_q[3:2], 5'h0} +: 32] :
                                             32'h0;

    // one wait state on reads so a write just before is always visible
    assign hreadyout = ~rdPend_q;
    assign hresp     = 1'b0;
    assign hrdata    = hrdata_q;

    always_ff @(posedge clk_sys or negedge rstSyncN_q) begin
        if (!rstSyncN_q) begin
            dpWrite_q  <= 1'b0;
            rdPend_q   <= 1'b0;
            dpMapped_q <= 1'b0;
            dpAddr_q   <= 8'h0;
            hrdata_q   <= 32'h0;
        end else begin
            dpWrite_q <= addrPhase & hwrite;
            rdPend_q  <= addrPhase & ~hwrite;
            if (addrPhase) begin
                dpAddr_q   <= haddr[7:0];
                dpMapped_q <= mapped;
            end
            if (rdPend_q) begin
                hrdata_q <= rdMux;
            end
        end
    end

    // command launch checks
    mtsop_cmd_s newCmd;
    assign newCmd = mtsop_cmd_s'(hwdata[CMD_WIDTH-1:0]);

    // array store needs only matrix and array enables
    wire  baseEn   = ctrl_q[CTRL_MAT_EN] & ctrl_q[CTRL_ARR_EN];
    wire  streamEn = baseEn & ctrl_q[CTRL_STREAM];
    wire  undef    = (newCmd.op == OP_OUT16) & ~WIDE_PRESENT;
    wire  disab    = (newCmd.op == OP_VEC) ? ~baseEn : ~streamEn;
    wire  misalign = (newCmd.op == OP_VEC) & ctrl_q[CTRL_ALIGN]
                   & (base_q[3:0] != 4'h0);
    wire  goCmd    = wrCmd & ~undef & ~disab & ~misalign;

    // tile slice store element path
    wire [31:0]  selW     = sliceW_q[cmd_q.sliceReg];
    wire [1:0]   sliceNum = selW[1:0] + cmd_q.imm[1:0];
    wire [3:0]   sliceRow = {sliceNum, cmd_q.tile[1:0]};
    wire [15:0]  predG    = pred_q[cmd_q.firstPred];
    wire         slicePb  = predG[{cnt_q[1:0], 2'h0}];
    wire [31:0]  offPlus  = offset_q + {27'h0, cnt_q};
    wire [31:0]  sliceAdr = base_q + {offPlus[29:0], 2'h0};
    wire [31:0]  sliceDat = za_q[sliceRow][{cnt_q[1:0], 5'h0} +: 32];

    // array vector store path
    // row wraps modulo sixteen
    wire [3:0]   vecRow   = selW[3:0] + cmd_q.imm;
    wire [31:0]  vecBase  = base_q + {24'h0, cmd_q.imm, 4'h0};
    wire [31:0]  vecAdr   = vecBase + {27'h0, cnt_q};
    wire [7:0]   vecByte  = za_q[vecRow][{cnt_q[3:0], 3'h0} +: 8];

    // outer product element path, one destination element per cycle
    wire         is16     = (cmd_q.op == OP_OUT16);
    wire [1:0]   row8     = cnt_q[3:2];
    wire [1:0]   col8     = cnt_q[1:0];
    wire         row16    = cnt_q[1];
    wire         col16    = cnt_q[0];
    wire [3:0]   zaRow8   = {row8, cmd_q.tile[1:0]};
    wire [3:0]   zaRow16  = {row16, cmd_q.tile[2:0]};
    wire [6:0]   lane8    = {col8, 5'h0};
    wire [6:0]   lane16   = {col16, 6'h0};
    wire [31:0]  old8     = za_q[zaRow8][lane8 +: 32];
    wire [63:0]  old16    = za_q[zaRow16][lane16 +: 64];
    wire [15:0]  predA    = pred_q[cmd_q.firstPred];
    wire [15:0]  predB    = pred_q[cmd_q.secondPred];
    wire [31:0]  prod8  [4];
    wire [63:0]  prod16 [4];

    genvar k;
    generate
        for (k = 0; k < 4; k++) begin : g_dot
            localparam logic [1:0] KI = 2'(k);
            wire [3:0]  ia8  = {row8, KI};
            wire [3:0]  ib8  = {col8, KI};
            wire [2:0]  ia16 = {row16, KI};
            wire [2:0]  ib16 = {col16, KI};
            wire [7:0]  a8   = predA[ia8] ? zn_q[{ia8, 3'h0} +: 8] : 8'h0;
            wire [7:0]  b8   = predB[ib8] ? zm_q[{ib8, 3'h0} +: 8] : 8'h0;
            wire [15:0] a16  = predA[{ia16, 1'b0}]
                             ? zn_q[{ia16, 4'h0} +: 16] : 16'h0;
            wire [15:0] b16  = predB[{ib16, 1'b0}]
                             ? zm_q[{ib16, 4'h0} +: 16] : 16'h0;
            // widened to 32 or 64 bits
            assign prod8[k]  = {{24{a8[7]}}, a8} * {24'h0, b8};
            assign prod16[k] = {{48{a16[15]}}, a16} * {48'h0, b16};
        end
    endgenerate

    wire [31:0]  sum8  = old8 + prod8[0] + prod8[1] + prod8[2] + prod8[3];
    wire [63:0]  sum16 = old16 + prod16[0] + prod16[1]
                       + prod16[2] + prod16[3];
    wire [4:0]   outLast = is16 ? OUT16_LAST : OUT8_LAST;

    // store sequencing; a held request stalls the element walk
    wire         stall    = reqValid_q & ~memReady;
    wire [4:0]   storeCnt = (state_q == ST_VEC) ? VEC_CNT : SLICE_CNT;
    wire         storeEnd = (cnt_q == storeCnt);

    assign memValid = reqValid_q;
    assign memReq   = req_q;
    assign busy     = ~idle;

    always_ff @(posedge clk_sys or negedge rstSyncN_q) begin
        if (!rstSyncN_q) begin
            state_q    <= ST_IDLE;
            cnt_q      <= 5'h0;
            reqValid_q <= 1'b0;
            req_q      <= '0;
            cmd_q      <= '0;
        end else begin
            unique case (state_q)
                ST_IDLE: begin
                    cnt_q <= 5'h0;
                    if (goCmd) begin
                        cmd_q <= newCmd;
                        unique case (newCmd.op)
                            OP_SLICE: state_q <= ST_SLICE;
                            OP_VEC:   state_q <= ST_VEC;
                            default:  state_q <= ST_OUTER;
                        endcase
                    end
                end
                ST_SLICE, ST_VEC: begin
                    if (!stall) begin
                        if (storeEnd) begin
                            reqValid_q <= 1'b0;
                            state_q    <= ST_IDLE;
                        end else if (state_q == ST_SLICE) begin
                            reqValid_q    <= slicePb;
                            req_q.addr    <= sliceAdr;
                            req_q.data    <= sliceDat;
                            req_q.byteOnly <= 1'b0;
                            cnt_q         <= cnt_q + 5'h1;
                        end else begin
                            reqValid_q    <= 1'b1;
                            req_q.addr    <= vecAdr;
                            req_q.data    <= {24'h0, vecByte};
                            req_q.byteOnly <= 1'b1;
                            cnt_q         <= cnt_q + 5'h1;
                        end
                    end
                end
                ST_OUTER: begin
                    cnt_q <= cnt_q + 5'h1;
                    if (cnt_q == outLast) begin
                        state_q <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // status: launch clears the sticky bits, the outcome sets them
    wire opEnd = ((state_q == ST_SLICE) | (state_q == ST_VEC))
               & ~stall & storeEnd
               | (state_q == ST_OUTER) & (cnt_q == outLast);

    always_ff @(posedge clk_sys or negedge rstSyncN_q) begin
        if (!rstSyncN_q) begin
            stat_q <= 5'h0;
            ctrl_q <= CTRL_RESET;
        end else begin
            if (wrCtrl) begin
                ctrl_q <= hwdata[3:0];
            end
            if (wrCmd) begin
                stat_q[STAT_UNDEF] <= undef;
                stat_q[STAT_DISAB] <= ~undef & disab;
                stat_q[STAT_ALIGN] <= ~undef & ~disab & misalign;
                stat_q[STAT_DONE]  <= 1'b0;
            end
            stat_q[STAT_BUSY] <= ~idle & ~opEnd | goCmd;
            if (opEnd) begin
                stat_q[STAT_DONE] <= 1'b1;
            end
        end
    end

    // operand registers, frozen while busy
    always_ff @(posedge clk_sys or negedge rstSyncN_q) begin
        if (!rstSyncN_q) begin
            base_q   <= 32'h0;
            offset_q <= 32'h0;
            zn_q     <= 128'h0;
            zm_q     <= 128'h0;
            for (int i = 0; i < 4; i++) begin
                sliceW_q[i] <= 32'h0;
            end
            for (int i = 0; i < NUM_PRED; i++) begin
                pred_q[i] <= 16'h0;
            end
        end else begin
            if (wrBase) begin
                base_q <= hwdata;
            end
            if (wrOffset) begin
                offset_q <= hwdata;
            end
            if (wrSliceW) begin
                sliceW_q[dpAddr_q[3:2]] <= hwdata;
            end
            if (wrPred) begin
                pred_q[dpAddr_q[4:2]] <= hwdata[PRED_BITS-1:0];
            end
            if (wrZn) begin
                zn_q[{dpAddr_q[3:2], 5'h0} +: 32] <= hwdata;
            end
            if (wrZm) begin
                zm_q[{dpAddr_q[3:2], 5'h0} +: 32] <= hwdata;
            end
        end
    end

    // matrix array storage; window index steps on each data read and on each data write while idle
    always_ff @(posedge clk_sys or negedge rstSyncN_q) begin
        if (!rstSyncN_q) begin
            zaIdx_q <= 6'h0;
            for (int i = 0; i < ZA_ROWS; i++) begin
                za_q[i] <= 128'h0;
            end
        end else begin
            if (wrZaIdx) begin
                zaIdx_q <= hwdata[5:0];
            end else if (wrZaData | rdZaData) begin
                zaIdx_q <= zaIdx_q + 6'h1;
            end
            if (wrZaData) begin
                za_q[zaRowBus][zaLaneBus +: 32] <= hwdata;
            end
            if (state_q == ST_OUTER) begin
                if (is16) begin
                    za_q[zaRow16][lane16 +: 64] <= sum16;
                end else begin
                    za_q[zaRow8][lane8 +: 32] <= sum8;
                end
            end
        end
    end

endmodule : mtsop_unit

// *** tb/mtsop_mem_model.sv ***
// memory side model that logs every accepted store request
`timescale 1ns/10ps
module mtsop_mem_model
    import mtsop_pkg::*;
(
    input wire logic          clk_sys,
    input wire logic          memValid,
    input wire mtsop_memreq_s memReq,
    input wire logic          slow,
    output logic              memReady
);
    mtsop_memreq_s logQ [$];
    logic [1:0]    cnt_q = 2'h0;

    // slow mode accepts one cycle in four to stretch every request
    assign memReady = !slow || cnt_q == 2'h3;

    always @(posedge clk_sys) begin
        cnt_q <= cnt_q + 2'h1;
        if (memValid && memReady) logQ.push_back(memReq);
    end
endmodule : mtsop_mem_model

// *** tb/mtsop_unit_properties.sv ***
// concurrent checks on the bus and store request ports
`timescale 1ns/10ps
module mtsop_unit_properties
    import mtsop_pkg::*;
(
    input wire logic          clk_sys,
    input wire logic          rstn,
    input wire logic          hsel,
    input wire logic [31:0]   haddr,
    input wire logic [1:0]    htrans,
    input wire logic          hwrite,
    input wire logic [2:0]    hsize,
    input wire logic [31:0]   hwdata,
    input wire logic          hready,
    input wire logic          hreadyout,
    input wire logic          hresp,
    input wire logic [31:0]   hrdata,
    input wire logic          memValid,
    input wire mtsop_memreq_s memReq,
    input wire logic          memReady,
    input wire logic          busy
);
    logic [4:0]  nByte_q;
    logic [4:0]  nWord_q;
    logic [31:0] lastAddr_q;
    wire         take = memValid && memReady;
    wire         reqRd = hsel && htrans[1] && hready && !hwrite;
    wire         reqWr = hsel && htrans[1] && hready && hwrite;

    // counts restart with every operation
    // busy is not a reset: clearing on it stays in the clocked branch
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            nByte_q    <= 5'h0;
            nWord_q    <= 5'h0;
            lastAddr_q <= 32'h0;
        end else if (!busy) begin
            nByte_q <= 5'h0;
            nWord_q <= 5'h0;
        end else if (take) begin
            nByte_q    <= nByte_q + 5'(memReq.byteOnly);
            nWord_q    <= nWord_q + 5'(!memReq.byteOnly);
            lastAddr_q <= memReq.addr;
        end
    end

    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    req_hold_a: assert property (
        memValid && !memReady |=> memValid && $stable(memReq))
        else $error("store request changed while stalled");
    req_busy_a: assert property (
        memValid |-> busy) else $error("store request while idle");
    byte_seq_a: assert property (
        memValid && memReq.byteOnly && nByte_q != 5'h0
        |-> memReq.addr == lastAddr_q + 32'h1)
        else $error("byte store address not sequential");
    byte_clean_a: assert property (
        memValid && memReq.byteOnly |-> memReq.data[31:8] == 24'h0)
        else $error("byte store carries upper bits");
    word_step_a: assert property (
        memValid && !memReq.byteOnly && nWord_q != 5'h0
        |-> (memReq.addr - lastAddr_q) inside {32'h4, 32'h8, 32'hc})
        else $error("word store address step wrong");
    byte_count_a: assert property (
        $fell(busy) |-> nByte_q == 5'h0 || nByte_q == 5'h10)
        else $error("vector store byte count wrong");
    word_count_a: assert property (
        $fell(busy) |-> nWord_q <= 5'h4
                        && !(nWord_q != 5'h0 && nByte_q != 5'h0))
        else $error("slice store word count wrong");
    read_wait_a: assert property (
        reqRd |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    write_fast_a: assert property (
        reqWr |=> hreadyout) else $error("write data phase stalled");
    resp_okay_a: assert property (
        hresp == 1'b0) else $error("error response seen");
endmodule : mtsop_unit_properties

bind mtsop_unit mtsop_unit_properties u_props (
    .clk_sys(clk_sys), .rstn(rstn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .memValid(memValid), .memReq(memReq),
    .memReady(memReady), .busy(busy));

// *** tb/mtsop_unit_test.sv ***
// self-checking bench of the tile store and outer product unit
`timescale 1ns/10ps
`define CHK(n, e, s) begin numChecks++; if ((s) !== (e)) begin \
    nErrors++; $display("CHECK FAILED %s exp %h got %h", n, e, s); end end
module mtsop_unit_test
    import mtsop_pkg::*;
;
    localparam logic [127:0] SRC1 = 128'h80ff7f01_fe028001_7fff1234_a5c35a3c;
    localparam logic [127:0] SRC2 = 128'hff80017f_00ffc3a5_ffff0001_8000e7d9;
    localparam logic [15:0]  PRD1 = 16'hb7ed;
    localparam logic [15:0]  PRD2 = 16'hfdbf;
    logic          clk_sys = 1'b0;
    logic          rstn = 1'b0;
    logic          hsel = 1'b0;
    logic          hwrite = 1'b0;
    logic          slow = 1'b0;
    logic [1:0]    htrans = 2'h0;
    logic [31:0]   haddr = 32'h0;
    logic [31:0]   hwdata = 32'h0;
    logic [31:0]   hrdata;
    logic [31:0]   r;
    logic          hreadyout;
    logic          memValid;
    logic          memReady;
    logic          busy;
    mtsop_memreq_s memReq;
    logic [31:0]   arr [64];
    int            nErrors = 0;
    int            numChecks = 0;
    int            cyc = 0;

    mtsop_unit u_dut (.clk_sys(clk_sys), .rstn(rstn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
        .hresp(), .hrdata(hrdata), .memValid(memValid), .memReq(memReq),
        .memReady(memReady), .busy(busy));
    mtsop_mem_model u_mem (.clk_sys(clk_sys), .memValid(memValid),
        .memReq(memReq), .slow(slow), .memReady(memReady));

    always #25 clk_sys = ~clk_sys;

    task automatic complete_run;
        $display("checks %0d errors %0d", numChecks, nErrors);
        if (nErrors == 0 && numChecks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : complete_run

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            nErrors++;
            complete_run();
        end
    end

    task automatic xfer(input logic w, input logic [7:0] a,
                        input logic [31:0] d);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, a};
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clk_sys); while (hreadyout !== 1'b1);
        r = hrdata;
    endtask : xfer

    task automatic rdc(input string n, input logic [7:0] a,
                       input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(n, e, r)
    endtask : rdc

    // launch, then poll until the unit goes idle again
    task automatic run(input logic [31:0] c);
        xfer(1'b1, OFS_CMD, c);
        do xfer(1'b0, OFS_STATUS, 32'h0); while (r[STAT_BUSY] !== 1'b0);
    endtask : run

    task automatic chkMem(input logic [31:0] a, input logic [31:0] d,
                          input logic b);
        mtsop_memreq_s m;
        m = '0;
        if (u_mem.logQ.size() != 0) m = u_mem.logQ.pop_front();
        `CHK("store", {a, d, b}, m)
    endtask : chkMem

    function automatic logic [31:0] mk(input logic [1:0] op,
        input logic [2:0] t, input logic [1:0] s, input logic [3:0] i,
        input logic [2:0] a, input logic [2:0] b);
        mtsop_cmd_s c;
        c = '{b, a, i, s, t, op};
        return 32'(c);
    endfunction : mk

    function automatic logic [63:0] dot(input int r0, input int c,
                                        input int w);
        longint s;
        int     i;
        int     j;
        int     a;
        int     b;
        s = 0;
        for (int k = 0; k < 4; k++) begin
            i = 4 * r0 + k;
            j = 4 * c + k;
            a = w ? int'($signed(SRC1[16*i+:16]))
                  : int'($signed(SRC1[8*i+:8]));
            b = w ? int'(SRC2[16*j+:16]) : int'(SRC2[8*j+:8]);
            if (PRD1[i << w] && PRD2[j << w]) s = s + longint'(a) * b;
        end
        return 64'(s);
    endfunction : dot

    // new words are worked out before the mirror is touched
    task automatic chkOp(input int w, input int t);
        logic [63:0] e;
        logic [31:0] nv [4];
        int          rw;
        for (int r0 = 0; r0 < (4 >> w); r0++) begin
            rw = (w != 0) ? r0 * 8 + t : r0 * 4 + t;
            for (int c = 0; c < 4; c++) begin
                e = (w != 0) ? {arr[rw*4+(c|1)], arr[rw*4+(c&2)]}
                             : {32'h0, arr[rw*4+c]};
                e = e + dot(r0, c >> w, w);
                nv[c] = (w != 0 && c[0]) ? e[63:32] : e[31:0];
            end
            xfer(1'b1, OFS_ZAIDX, 32'(rw * 4));
            for (int c = 0; c < 4; c++) begin
                arr[rw*4+c] = nv[c];
                rdc("tile word", OFS_ZADATA, nv[c]);
            end
        end
    endtask : chkOp

    initial begin
        repeat (10) @(posedge clk_sys);
        rstn <= 1'b1;
        repeat (3) @(posedge clk_sys);
        rdc("ident", OFS_ID, 32'h1);
        rdc("control", OFS_CTRL, 32'h0);
        rdc("unmapped", 8'hfc, 32'h0);
        xfer(1'b1, OFS_ZAIDX, 32'h0);
        for (int i = 0; i < 64; i++) begin
            arr[i] = 32'hfedcba98 + 32'(i) * 32'h13579bdf;
            xfer(1'b1, OFS_ZADATA, arr[i]);
        end
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, OFS_ZN + 8'(4 * i), SRC1[32*i+:32]);
            xfer(1'b1, OFS_ZM + 8'(4 * i), SRC2[32*i+:32]);
        end
        xfer(1'b1, OFS_SLICEW + 8'h4, 32'h6);
        xfer(1'b1, OFS_SLICEW + 8'h8, 32'h1e);
        xfer(1'b1, OFS_BASE, 32'h1000);
        xfer(1'b1, OFS_OFFSET, 32'h2);
        xfer(1'b1, OFS_PRED + 8'h4, 32'h1001);
        xfer(1'b1, OFS_PRED + 8'h8, 32'(PRD1));
        xfer(1'b1, OFS_PRED + 8'hc, 32'(PRD2));
        xfer(1'b1, OFS_CTRL, 32'h3);
        run(mk(OP_SLICE, 3'h3, 2'h1, 4'hb, 3'h1, 3'h0));
        rdc("disabled", OFS_STATUS, 32'h8);
        xfer(1'b1, OFS_CTRL, 32'h7);
        run(mk(OP_SLICE, 3'h3, 2'h1, 4'hb, 3'h1, 3'h0));
        rdc("status", OFS_STATUS, 32'h10);
        chkMem(32'h1008, arr[28], 1'b0);
        chkMem(32'h1014, arr[31], 1'b0);
        xfer(1'b1, OFS_CTRL, 32'hb);
        xfer(1'b1, OFS_BASE, 32'h2000);
        slow <= 1'b1;
        run(mk(OP_VEC, 3'h0, 2'h2, 4'h5, 3'h0, 3'h0));
        slow <= 1'b0;
        rdc("status", OFS_STATUS, 32'h10);
        for (int e = 0; e < 16; e++)
            chkMem(32'h2050 + 32'(e),
                {24'h0, arr[12+e/4][8*(e%4)+:8]}, 1'b1);
        xfer(1'b1, OFS_BASE, 32'h2008);
        run(mk(OP_VEC, 3'h0, 2'h2, 4'h5, 3'h0, 3'h0));
        rdc("status", OFS_STATUS, 32'h2);
        xfer(1'b1, OFS_CTRL, 32'h7);
        run(mk(OP_OUT8, 3'h1, 2'h0, 4'h0, 3'h2, 3'h3));
        chkOp(0, 1);
        run(mk(OP_OUT16, 3'h5, 2'h0, 4'h0, 3'h2, 3'h3));
        chkOp(1, 5);
        `CHK("queue", 32'h0, 32'(u_mem.logQ.size()))
        complete_run();
    end
endmodule : mtsop_unit_test
